// [design/isa_bridge_pkg.sv]
// Constants, types and the state record shared by the DMA status and ISA window bridge.
package isa_bridge_pkg;

	// ------------------------------------------------------------------
	// Register indices; the AHB byte address is four times the index.
	// ------------------------------------------------------------------
	localparam logic [15:0] IO_WINDOW_BASE_IDX  = 16'h7F71;
	localparam logic [15:0] MEM_WINDOW_BASE_IDX = 16'h7F72;
	localparam logic [15:0] STATUS_VIEW_IDX     = 16'h7F73;
	localparam logic [15:0] DMA_STATUS_MASK_IDX = 16'h7F74;
	localparam logic [15:0] INT_STATUS0_IDX     = 16'h7F75;
	localparam logic [15:0] INT_ENABLE0_IDX     = 16'h7F76;

	// ------------------------------------------------------------------
	// AHB byte bases of the two windows; each window byte takes one word.
	// ------------------------------------------------------------------
	localparam logic [31:0] IO_WINDOW_AHB  = 32'h0000_4000;
	localparam logic [31:0] MEM_WINDOW_AHB = 32'h0000_8000;

	// ------------------------------------------------------------------
	// Reset values and field positions.
	// ------------------------------------------------------------------
	localparam logic [7:0] IO_BASE_RST   = 8'h00;
	localparam logic [7:0] MEM_BASE_RST  = 8'h00;
	localparam logic [7:0] MASK_RST      = 8'hFF;
	localparam logic       INT_EN_RST    = 1'h0;
	localparam int         DMA_EVENT_BIT = 0;

	// ------------------------------------------------------------------
	// ISA cycle timing at a 125 MHz clock; least times round up.
	// ------------------------------------------------------------------
	localparam int         CLK_PERIOD_PS = 8000;
	localparam int         ISA_SETUP_NS  = 40;
	localparam int         ISA_STROBE_NS = 200;
	localparam logic [7:0] SETUP_CYCLES  = 8'((ISA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [7:0] STROBE_CYCLES = 8'((ISA_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// ------------------------------------------------------------------
	// Types.
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_REG    = 6'b000010,
		ST_WAIT   = 6'b000100,
		ST_SETUP  = 6'b001000,
		ST_STROBE = 6'b010000,
		ST_DONE   = 6'b100000
	} state_t;

	typedef enum logic [3:0] {
		SEL_NONE  = 4'h0,
		SEL_IOB   = 4'h1,
		SEL_MEMB  = 4'h2,
		SEL_VIEW  = 4'h3,
		SEL_MASK  = 4'h4,
		SEL_ISTAT = 4'h5,
		SEL_IEN   = 4'h6,
		SEL_IOWIN = 4'h7,
		SEL_MEMWIN = 4'h8
	} sel_t;

	typedef struct packed {
		state_t      state;
		sel_t        sel;
		logic        wr;
		logic [11:0] offset;
		logic [7:0]  cnt;
		logic [19:0] isa_addr;
		logic [7:0]  isa_dout;
		logic        isa_oe;
		logic        ior_n;
		logic        iow_n;
		logic        memr_n;
		logic        memw_n;
		logic [31:0] rdata;
		logic [7:0]  view_s1;
		logic [7:0]  view;
		logic [7:0]  view_prev;
		logic        event_flag;
		logic        int_en;
		logic [7:0]  mask;
		logic [7:0]  io_base;
		logic [7:0]  mem_base;
		logic [7:0]  din_s1;
		logic [7:0]  din;
		logic        own_s1;
		logic        own;
	} regs_t;

	localparam regs_t REGS_RST = '{
		state:      ST_IDLE,
		sel:        SEL_NONE,
		wr:         1'h0,
		offset:     12'h000,
		cnt:        8'h00,
		isa_addr:   20'h00000,
		isa_dout:   8'h00,
		isa_oe:     1'h0,
		ior_n:      1'h1,
		iow_n:      1'h1,
		memr_n:     1'h1,
		memw_n:     1'h1,
		rdata:      32'h0000_0000,
		view_s1:    8'h00,
		view:       8'h00,
		view_prev:  8'h00,
		event_flag: 1'h0,
		int_en:     INT_EN_RST,
		mask:       MASK_RST,
		io_base:    IO_BASE_RST,
		mem_base:   MEM_BASE_RST,
		din_s1:     8'h00,
		din:        8'h00,
		own_s1:     1'h0,
		own:        1'h0
	};

endpackage

// [design/isa_dma_window_bridge.sv]
// DMA status view, DMA event interrupt and ISA I/O and memory windows behind an AHB-Lite slave.
//
// Notes on behaviour
// - Status view follows the DMA core channel status bits continuously.
// - View bits 7..4 are channel 3..0 requests, bits 3..0 terminal counts.
// - An I/O window read of the core's status lets the core clear its count bits.
// - Reading the status view changes nothing.
// - A rising enabled view bit latches the DMA event flag high.
// - The status view is readable while the DMA core owns the ISA bus.
// - Unmasked request bits raise events when requests become active; masked ones just monitor.
// - Mask bits 7..4 gate request sources, bits 3..0 terminal-count sources.
// - Mask bit 0 enables its source, 1 blocks it.
// - The mask register resets to all ones.
// - I/O address is the I/O base as bits 15:8 with the 8-bit offset.
// - I/O window reads and writes run ISA I/O read and write cycles.
// - Memory address is the memory base as bits 19:12 with the 12-bit offset.
// - The I/O base is read/write, eight bits wide, reset to zero.
// - The memory base is read/write and resets to zero.
`timescale 1ns/1ps

module isa_dma_window_bridge (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// AHB-Lite slave.
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// DMA core status and bus ownership.
	input  wire logic [7:0]  dma_core_channel_status_in,
	input  wire logic        dma_owns_bus_in,
	// ISA bus.
	output logic      [19:0] isa_addr_out,
	input  wire logic [7:0]  isa_data_in,
	output logic      [7:0]  isa_data_out,
	output logic             isa_data_oe_out,
	output logic             isa_ior_n_out,
	output logic             isa_iow_n_out,
	output logic             isa_memr_n_out,
	output logic             isa_memw_n_out,
	// Interrupt.
	output logic             irq_out
);

	isa_bridge_pkg::regs_t r;
	isa_bridge_pkg::regs_t n;
	logic [7:0]            rise;
	logic                  accept;
	logic                  is_win;

	// ------------------------------------------------------------
	// Address decode.
	// ------------------------------------------------------------
	function automatic isa_bridge_pkg::sel_t decode(input logic [31:0] a);
		isa_bridge_pkg::sel_t s;
		s = isa_bridge_pkg::SEL_NONE;
		if (a[31:10] == isa_bridge_pkg::IO_WINDOW_AHB[31:10]) begin
			s = isa_bridge_pkg::SEL_IOWIN;
		end else if (a[31:14] == isa_bridge_pkg::MEM_WINDOW_AHB[31:14]) begin
			s = isa_bridge_pkg::SEL_MEMWIN;
		end else if (a[31:2] == {14'h0000, isa_bridge_pkg::IO_WINDOW_BASE_IDX}) begin
			s = isa_bridge_pkg::SEL_IOB;
		end else if (a[31:2] == {14'h0000, isa_bridge_pkg::MEM_WINDOW_BASE_IDX}) begin
			s = isa_bridge_pkg::SEL_MEMB;
		end else if (a[31:2] == {14'h0000, isa_bridge_pkg::STATUS_VIEW_IDX}) begin
			s = isa_bridge_pkg::SEL_VIEW;
		end else if (a[31:2] == {14'h0000, isa_bridge_pkg::DMA_STATUS_MASK_IDX}) begin
			s = isa_bridge_pkg::SEL_MASK;
		end else if (a[31:2] == {14'h0000, isa_bridge_pkg::INT_STATUS0_IDX}) begin
			s = isa_bridge_pkg::SEL_ISTAT;
		end else if (a[31:2] == {14'h0000, isa_bridge_pkg::INT_ENABLE0_IDX}) begin
			s = isa_bridge_pkg::SEL_IEN;
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// Bus handshake outputs.
	// ------------------------------------------------------------
	assign hreadyout_out = (r.state == isa_bridge_pkg::ST_IDLE) || (r.state == isa_bridge_pkg::ST_REG) ||
	                       (r.state == isa_bridge_pkg::ST_DONE);
	assign hresp_out     = 1'b0;
	assign hrdata_out    = r.rdata;
	assign accept        = hreadyout_out && hsel_in && htrans_in[1] && hready_in;

	// ------------------------------------------------------------
	// Pin and data outputs from flip-flops; irq_out is the AND of two of them.
	// ------------------------------------------------------------
	assign isa_addr_out    = r.isa_addr;
	assign isa_data_out    = r.isa_dout;
	assign isa_data_oe_out = r.isa_oe;
	assign isa_ior_n_out   = r.ior_n;
	assign isa_iow_n_out   = r.iow_n;
	assign isa_memr_n_out  = r.memr_n;
	assign isa_memw_n_out  = r.memw_n;
	assign irq_out         = r.event_flag & r.int_en;

	// ------------------------------------------------------------
	// Next state.
	// ------------------------------------------------------------
	always_comb begin
		n      = r;
		is_win = 1'b0;

		// Status view and other foreign inputs pass two flip-flops.
		n.view_s1   = dma_core_channel_status_in;
		n.view      = r.view_s1;
		n.view_prev = r.view;
		n.din_s1    = isa_data_in;
		n.din       = r.din_s1;
		n.own_s1    = dma_owns_bus_in;
		n.own       = r.own_s1;

		rise = r.view & ~r.view_prev;

		case (r.state)
			isa_bridge_pkg::ST_IDLE: begin
				n.state = isa_bridge_pkg::ST_IDLE;
			end
			isa_bridge_pkg::ST_REG: begin
				n.state = isa_bridge_pkg::ST_IDLE;
				if (r.wr) begin
					case (r.sel)
						isa_bridge_pkg::SEL_IOB: begin
							n.io_base = hwdata_in[7:0];
						end
						isa_bridge_pkg::SEL_MEMB: begin
							n.mem_base = hwdata_in[7:0];
						end
						isa_bridge_pkg::SEL_MASK: begin
							n.mask = hwdata_in[7:0];
						end
						isa_bridge_pkg::SEL_ISTAT: begin
							if (hwdata_in[isa_bridge_pkg::DMA_EVENT_BIT]) begin
								n.event_flag = 1'b0;
							end
						end
						isa_bridge_pkg::SEL_IEN: begin
							n.int_en = hwdata_in[isa_bridge_pkg::DMA_EVENT_BIT];
						end
						default: begin
							n.state = isa_bridge_pkg::ST_IDLE;
						end
					endcase
				end
			end
			isa_bridge_pkg::ST_WAIT: begin
				// The window waits while the DMA core holds the ISA bus.
				if (!r.own) begin
					n.state    = isa_bridge_pkg::ST_SETUP;
					n.cnt      = isa_bridge_pkg::SETUP_CYCLES - 8'h01;
					n.isa_dout = hwdata_in[7:0];
					n.isa_oe   = r.wr;
					if (r.sel == isa_bridge_pkg::SEL_IOWIN) begin
						n.isa_addr = {4'h0, r.io_base, r.offset[7:0]};
					end else begin
						n.isa_addr = {r.mem_base, r.offset};
					end
				end
			end
			isa_bridge_pkg::ST_SETUP: begin
				if (r.cnt == 8'h00) begin
					n.state = isa_bridge_pkg::ST_STROBE;
					n.cnt   = isa_bridge_pkg::STROBE_CYCLES - 8'h01;
					if (r.sel == isa_bridge_pkg::SEL_IOWIN) begin
						n.ior_n = r.wr;
						n.iow_n = ~r.wr;
					end else begin
						n.memr_n = r.wr;
						n.memw_n = ~r.wr;
					end
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			isa_bridge_pkg::ST_STROBE: begin
				if (r.cnt == 8'h00) begin
					n.state  = isa_bridge_pkg::ST_DONE;
					n.ior_n  = 1'b1;
					n.iow_n  = 1'b1;
					n.memr_n = 1'b1;
					n.memw_n = 1'b1;
					n.rdata  = r.wr ? 32'h0000_0000 : {24'h000000, r.din};
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			isa_bridge_pkg::ST_DONE: begin
				n.state  = isa_bridge_pkg::ST_IDLE;
				n.isa_oe = 1'b0;
			end
			default: begin
				n.state = isa_bridge_pkg::ST_IDLE;
			end
		endcase

		// A rising enabled source sets the flag; the set wins over a clear.
		if (|(rise & ~r.mask)) begin
			n.event_flag = 1'b1;
		end

		// Address phase; register read data is captured here.
		if (accept) begin
			n.sel    = decode(haddr_in);
			n.wr     = hwrite_in;
			n.rdata  = 32'h0000_0000;
			n.offset = 12'h000;
			case (n.sel)
				isa_bridge_pkg::SEL_IOB: begin
					n.rdata = {24'h000000, r.io_base};
				end
				isa_bridge_pkg::SEL_MEMB: begin
					n.rdata = {24'h000000, r.mem_base};
				end
				isa_bridge_pkg::SEL_VIEW: begin
					n.rdata = {24'h000000, r.view};
				end
				isa_bridge_pkg::SEL_MASK: begin
					n.rdata = {24'h000000, r.mask};
				end
				isa_bridge_pkg::SEL_ISTAT: begin
					n.rdata = {31'h0000_0000, r.event_flag};
				end
				isa_bridge_pkg::SEL_IEN: begin
					n.rdata = {31'h0000_0000, r.int_en};
				end
				isa_bridge_pkg::SEL_IOWIN: begin
					is_win   = 1'b1;
					n.offset = {4'h0, haddr_in[9:2]};
				end
				isa_bridge_pkg::SEL_MEMWIN: begin
					is_win   = 1'b1;
					n.offset = haddr_in[13:2];
				end
				default: begin
					n.rdata = 32'h0000_0000;
				end
			endcase
			if (hwrite_in) begin
				n.rdata = 32'h0000_0000;
			end
			n.state = is_win ? isa_bridge_pkg::ST_WAIT : isa_bridge_pkg::ST_REG;
		end
	end

	// ------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r <= isa_bridge_pkg::REGS_RST;
		end else begin
			r <= n;
		end
	end

endmodule

// [tb/isa_bridge_chk.sv]
// Port checker for the DMA status and ISA window bridge.
`timescale 1ns/1ps
module isa_bridge_chk (
	input wire logic        clk_in, resetn_in, hsel_in, hready_in,
	input wire logic [31:0] haddr_in, hrdata_out,
	input wire logic [1:0]  htrans_in,
	input wire logic        hreadyout_out, hresp_out, isa_data_oe_out,
	input wire logic [19:0] isa_addr_out,
	input wire logic        isa_ior_n_out, isa_iow_n_out, isa_memr_n_out, isa_memw_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	wire logic [3:0] stb = {isa_ior_n_out, isa_iow_n_out, isa_memr_n_out, isa_memw_n_out};
	wire logic       req = hsel_in && htrans_in[1] && hready_in && hreadyout_out;
	sequence reg_req;
		req && haddr_in[16];
	endsequence
	sequence win_req;
		req && haddr_in[31:16] == 16'h0 && (haddr_in[15:10] == 6'h10 || haddr_in[15:14] == 2'h2);
	endsequence
	a_reg_no_wait: assert property (reg_req |=> hreadyout_out) else $error("register access waited");
	a_win_stall: assert property (win_req |=> !hreadyout_out [*8]) else $error("window access not stalled");
	a_one_strobe: assert property ($countones(~stb) <= 1) else $error("two strobes low");
	a_oe_on_write: assert property (isa_data_oe_out |-> isa_ior_n_out && isa_memr_n_out) else $error("oe in read");
	a_strobe_long: assert property ($fell(isa_iow_n_out) |-> !isa_iow_n_out [*8]) else $error("short strobe");
	a_addr_held: assert property (stb != 4'hF |-> $stable(isa_addr_out)) else $error("address moved");
	a_io_in_64k: assert property (!(isa_ior_n_out && isa_iow_n_out) |-> isa_addr_out[19:16] == 4'h0)
		else $error("io address above 64k");
	a_ready_strobe: assert property (stb != 4'hF |-> !hreadyout_out) else $error("ready during strobe");
	a_rdata_byte: assert property (hrdata_out[31:8] == 24'h0 && !hresp_out) else $error("bad read word");
endmodule
bind isa_dma_window_bridge isa_bridge_chk i_isa_bridge_chk (.clk_in, .resetn_in, .hsel_in, .hready_in, .haddr_in,
	.hrdata_out, .htrans_in, .hreadyout_out, .hresp_out, .isa_data_oe_out, .isa_addr_out, .isa_ior_n_out,
	.isa_iow_n_out, .isa_memr_n_out, .isa_memw_n_out);

// [tb/isa_periph_model.sv]
// ISA peripheral model: answers reads from the address and records the last write.
`timescale 1ns/1ps
module isa_periph_model (
	input  wire logic [19:0] addr_in,
	input  wire logic [7:0]  data_in,
	input  wire logic        ior_n_in, iow_n_in, memr_n_in, memw_n_in,
	output logic      [7:0]  data_out,
	output logic      [19:0] wr_addr_out,
	output logic      [7:0]  wr_data_out,
	output logic             wr_mem_out
);
	logic [7:0] last = 8'h00;
	wire logic       rd = !ior_n_in || !memr_n_in;
	wire logic [7:0] val = addr_in[7:0] ^ addr_in[19:12] ^ (!memr_n_in ? 8'h5A : 8'h00);
	// Released lines show the inverse of the last value so stale data cannot match.
	assign data_out = rd ? val : ~last;
	always @(negedge rd) begin
		last <= val;
	end
	always @(negedge iow_n_in or negedge memw_n_in) begin
		wr_mem_out <= !memw_n_in;
	end
	always @(posedge iow_n_in or posedge memw_n_in) begin
		wr_addr_out <= addr_in;
		wr_data_out <= data_in;
	end
endmodule

// [tb/tb_isa_dma_window_bridge.sv]
// Self-checking bench for the DMA status and ISA window bridge.
`timescale 1ns/1ps
module tb_isa_dma_window_bridge;
	logic        clk_in = 1'h0, resetn_in = 1'h0, hsel = 1'h0, hwrite = 1'h0, own = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0]  st = 8'h0, din, dout, wd;
	logic [19:0] isa_addr, wa;
	logic        hready, hresp, oe, ior, iow, memr, memw, irq, wm;
	int          n_fail = 0, cmp_count = 0;
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	isa_dma_window_bridge i_isa_dma_window_bridge (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.dma_core_channel_status_in(st), .dma_owns_bus_in(own), .isa_addr_out(isa_addr), .isa_data_in(din),
		.isa_data_out(dout), .isa_data_oe_out(oe), .isa_ior_n_out(ior), .isa_iow_n_out(iow),
		.isa_memr_n_out(memr), .isa_memw_n_out(memw), .irq_out(irq));
	isa_periph_model i_isa_periph_model (.addr_in(isa_addr), .data_in(dout), .ior_n_in(ior), .iow_n_in(iow),
		.memr_n_in(memr), .memw_n_in(memw), .data_out(din), .wr_addr_out(wa), .wr_data_out(wd), .wr_mem_out(wm));
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wt(input int c);
		repeat (c) @(posedge clk_in);
	endtask
	task hwait;
		int k;
		k = 0;
		@(posedge clk_in);
		while (hready !== 1'h1) begin
			k++;
			if (k > 500) begin
				n_fail++;
				finish_test;
			end
			@(posedge clk_in);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hwait;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
		rd = hrdata;
	endtask
	function logic [31:0] ra(input logic [15:0] ix);
		return {14'h0, ix, 2'h0};
	endfunction
	function logic [7:0] exp_rd(input logic [19:0] a, input logic m);
		return a[7:0] ^ a[19:12] ^ (m ? 8'h5A : 8'h00);
	endfunction
	initial begin
		logic [15:0] ix [5];
		logic [7:0]  ex [5];
		logic [7:0]  iob, mb, o, d, m;
		logic [11:0] om;
		ix = '{isa_bridge_pkg::IO_WINDOW_BASE_IDX, isa_bridge_pkg::MEM_WINDOW_BASE_IDX,
			isa_bridge_pkg::DMA_STATUS_MASK_IDX, isa_bridge_pkg::INT_ENABLE0_IDX, 16'h7F7F};
		ex = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
		void'($urandom(81));
		wt(6);
		resetn_in <= 1'h1;
		wt(1);
		bus(1'h1, ra(16'h7F7F), 32'hA5);
		for (int i = 0; i < 5; i++) begin
			bus(1'h0, ra(ix[i]), 32'h0);
			chk(rd, {24'h0, ex[i]});
		end
		$display("reset values done");
		bus(1'h1, ra(ix[3]), 32'h1);
		for (int k = 0; k < 4; k++) begin
			{iob, mb, o, d} = $urandom;
			om = 12'($urandom);
			bus(1'h1, ra(ix[0]), {24'h0, iob});
			bus(1'h1, ra(ix[1]), {24'h0, mb});
			bus(1'h0, ra(ix[0]), 32'h0);
			chk(rd, {24'h0, iob});
			bus(1'h0, ra(ix[1]), 32'h0);
			chk(rd, {24'h0, mb});
			bus(1'h1, 32'h4000 + {o, 2'h0}, {24'h0, d});
			chk({wm, wa, wd}, {1'h0, 4'h0, iob, o, d});
			bus(1'h0, 32'h4000 + {o, 2'h0}, 32'h0);
			chk(rd, exp_rd({4'h0, iob, o}, 1'h0));
			bus(1'h1, 32'h8000 + {om, 2'h0}, {24'h0, ~d});
			chk({wm, wa, wd}, {1'h1, mb, om, ~d});
			bus(1'h0, 32'h8000 + {om, 2'h0}, 32'h0);
			chk(rd, exp_rd({mb, om}, 1'h1));
			d = $urandom;
			own <= 1'h1;
			st <= d;
			wt(4);
			bus(1'h0, ra(isa_bridge_pkg::STATUS_VIEW_IDX), 32'h0);
			chk(rd, {24'h0, d});
			bus(1'h0, ra(isa_bridge_pkg::STATUS_VIEW_IDX), 32'h0);
			chk(rd, {24'h0, d});
			chk(irq, 1'h0);
			own <= 1'h0;
		end
		$display("windows and view done");
		bus(1'h1, ra(ix[3]), 32'h1);
		for (int i = 0; i < 8; i++) begin
			m = ~(8'h1 << i);
			st <= 8'h0;
			wt(6);
			bus(1'h1, ra(isa_bridge_pkg::INT_STATUS0_IDX), 32'h1);
			bus(1'h1, ra(ix[2]), {24'h0, m});
			st <= m;
			wt(6);
			chk(irq, 1'h0);
			st <= 8'hFF;
			wt(6);
			chk(irq, 1'h1);
			bus(1'h0, ra(isa_bridge_pkg::INT_STATUS0_IDX), 32'h0);
			chk(rd, 32'h1);
			st <= m;
			wt(6);
			chk(irq, 1'h1);
			st <= 8'hFF;
			bus(1'h1, ra(isa_bridge_pkg::INT_STATUS0_IDX), 32'h1);
			wt(6);
			bus(1'h1, ra(isa_bridge_pkg::INT_STATUS0_IDX), 32'h1);
			wt(6);
			chk(irq, 1'h0);
			bus(1'h0, ra(isa_bridge_pkg::INT_STATUS0_IDX), 32'h0);
			chk(rd, 32'h0);
		end
		$display("events done");
		finish_test;
	end
endmodule
